/* hw/pdt_deadband_trigger.v */
`timescale 1ns/1ns
`include "pdt_regs.vh"
module pdt_deadband_trigger #(
    parameter DW = 14
) (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // time base, same clock domain
    input wire timebase_clock,
    input wire timebase_half,
    input wire count_at_zero,
    input wire count_at_period,
    input wire [3:0] up_compare_match,
    input wire [3:0] down_compare_match,
    input wire dig_cmp_a_event1,
    input wire dig_cmp_b_event1,
    // live delay values
    input wire [DW-1:0] rise_live,
    input wire [DW-1:0] fall_live,
    // action-qualified inputs
    input wire pwm_in_a,
    input wire pwm_in_b,
    // outputs
    output reg pwm_out_a,
    output reg pwm_out_b,
    output reg conv_trigger_a,
    output reg conv_trigger_b,
    output reg irq
);
////////////////////////////////////////////////////////////////////////////////
reg [`PDT_DBCTL_W-1:0] dbctl_reg;
reg [DW-1:0] rise_edge_delay_reg;
reg [DW-1:0] fall_edge_delay_reg;
reg [23:0] trig_reg;
reg [31:0] rd_next;
reg [31:0] prdata_next;
wire [1:0] ev_cnt [0:2];
// transfer phases
wire setup_phase = psel && !penable;
wire wr = psel && penable && pwrite;
wire rd = setup_phase && !pwrite;
// address decode
wire hit_dbctl = (paddr == `PDT_OFS_DBCTL);
wire hit_rise = (paddr == `PDT_OFS_RISE);
wire hit_fall = (paddr == `PDT_OFS_FALL);
wire hit_trig = (paddr == `PDT_OFS_TRIG);
wire hit_stat = (paddr == `PDT_OFS_STAT);
wire mapped = hit_dbctl || hit_rise || hit_fall || hit_trig || hit_stat;
// status: live output levels and the three prescale counts
wire [7:0] stat_word = {ev_cnt[2], ev_cnt[1], ev_cnt[0], pwm_out_b, pwm_out_a};
// read data mux; unmapped offsets read as zero
always @* begin
    rd_next = 32'h0000_0000;
    case (paddr)
        `PDT_OFS_DBCTL: rd_next = {24'h00_0000, dbctl_reg};
        `PDT_OFS_RISE: rd_next = {{(32-DW){1'b0}}, rise_edge_delay_reg};
        `PDT_OFS_FALL: rd_next = {{(32-DW){1'b0}}, fall_edge_delay_reg};
        `PDT_OFS_TRIG: rd_next = {8'h00, trig_reg};
        `PDT_OFS_STAT: rd_next = {24'h00_0000, stat_word};
        default: rd_next = 32'h0000_0000;
    endcase
end
// reads load the mux at setup; writes answer with zero data
always @* begin
    prdata_next = prdata;
    if (rd) begin
        prdata_next = rd_next;
    end else if (setup_phase) begin
        prdata_next = 32'h0000_0000;
    end
end
////////////////////////////////////////////////////////////////////////////////
// zero wait state: setup cycle loads read data, access cycle completes
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
    end else begin
        pready <= setup_phase;
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pslverr <= 1'b0;
    end else begin
        pslverr <= setup_phase && !mapped;
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    end else begin
        prdata <= prdata_next;
    end
end
////////////////////////////////////////////////////////////////////////////////
// control: dead-band enables, polarity, sources, delay source
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        dbctl_reg <= {`PDT_DBCTL_W{1'b0}};
    end else if (wr && hit_dbctl) begin
        dbctl_reg <= pwdata[`PDT_DBCTL_W-1:0];
    end
end
// fixed rise delay, cut to the counter width
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rise_edge_delay_reg <= {DW{1'b0}};
    end else if (wr && hit_rise) begin
        rise_edge_delay_reg <= pwdata[DW-1:0];
    end
end
// fixed fall delay, cut to the counter width
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        fall_edge_delay_reg <= {DW{1'b0}};
    end else if (wr && hit_fall) begin
        fall_edge_delay_reg <= pwdata[DW-1:0];
    end
end
// trigger control, one byte per path
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        trig_reg <= 24'h00_0000;
    end else if (wr && hit_trig) begin
        trig_reg <= pwdata[23:0];
    end
end
////////////////////////////////////////////////////////////////////////////////
// dead-band
wire half = dbctl_reg[`PDT_DB_HALF];
wire en_a = dbctl_reg[`PDT_DB_EN_A];
wire en_b = dbctl_reg[`PDT_DB_EN_B];
wire rise_from_b = dbctl_reg[`PDT_DB_RSRC];
wire fall_from_b = dbctl_reg[`PDT_DB_FSRC];
wire use_live = dbctl_reg[`PDT_DB_LIVE];
// half-cycle mode takes the mid-cycle pulse as a second tick
wire tick = half ? (timebase_clock | timebase_half) : timebase_clock;
wire [1:0] pol = {dbctl_reg[`PDT_DB_POL_HI], dbctl_reg[`PDT_DB_POL_LO]};
wire rise_src = rise_from_b ? pwm_in_b : pwm_in_a;
wire fall_src = fall_from_b ? pwm_in_b : pwm_in_a;
wire [DW-1:0] rise_val = use_live ? rise_live : rise_edge_delay_reg;
wire [DW-1:0] fall_val = use_live ? fall_live : fall_edge_delay_reg;
reg rise_prev_reg;
reg fall_prev_reg;
reg [DW-1:0] rise_cnt_reg;
reg [DW-1:0] fall_cnt_reg;
reg rise_out_reg;
reg fall_out_reg;
reg [DW-1:0] rise_cnt_next;
reg [DW-1:0] fall_cnt_next;
reg rise_out_next;
reg fall_out_next;
wire [DW-1:0] rise_cnt_inc = rise_cnt_reg + {{(DW-1){1'b0}}, 1'b1};
wire [DW-1:0] fall_cnt_inc = fall_cnt_reg + {{(DW-1){1'b0}}, 1'b1};
wire rise_edge = rise_src && !rise_prev_reg;
wire fall_edge = !fall_src && fall_prev_reg;
////////////////////////////////////////////////////////////////////////////////
// source history for edge detection; resets to the idle low level
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rise_prev_reg <= 1'b0;
        fall_prev_reg <= 1'b0;
    end else begin
        rise_prev_reg <= rise_src;
        fall_prev_reg <= fall_src;
    end
end
// rising edges of the source are held off by the delay count; a tick that
// coincides with the edge is not counted, so a count of n spans n full ticks
always @* begin
    rise_cnt_next = rise_cnt_reg;
    rise_out_next = rise_out_reg;
    if (!rise_src) begin
        rise_out_next = 1'b0;
        rise_cnt_next = {DW{1'b0}};
    end else if (rise_edge) begin
        rise_out_next = (rise_val == {DW{1'b0}});
        rise_cnt_next = {DW{1'b0}};
    end else if (!rise_out_reg && tick) begin
        if (rise_cnt_inc >= rise_val) begin
            rise_out_next = 1'b1;
        end
        rise_cnt_next = rise_cnt_inc;
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rise_cnt_reg <= {DW{1'b0}};
        rise_out_reg <= 1'b0;
    end else begin
        rise_cnt_reg <= rise_cnt_next;
        rise_out_reg <= rise_out_next;
    end
end
// falling edge delay: output stays high for the count after the source falls
always @* begin
    fall_cnt_next = fall_cnt_reg;
    fall_out_next = fall_out_reg;
    if (fall_src) begin
        fall_out_next = 1'b1;
        fall_cnt_next = {DW{1'b0}};
    end else if (fall_edge) begin
        fall_out_next = (fall_val != {DW{1'b0}});
        fall_cnt_next = {DW{1'b0}};
    end else if (fall_out_reg && tick) begin
        if (fall_cnt_inc >= fall_val) begin
            fall_out_next = 1'b0;
        end
        fall_cnt_next = fall_cnt_inc;
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        fall_cnt_reg <= {DW{1'b0}};
        fall_out_reg <= 1'b0;
    end else begin
        fall_cnt_reg <= fall_cnt_next;
        fall_out_reg <= fall_out_next;
    end
end
// a is delayed-rise, b is inverse of delayed-fall; both low while either waits
wire a_act = en_a ? rise_out_reg : pwm_in_a;
wire b_act = en_b ? !fall_out_reg : pwm_in_b;
////////////////////////////////////////////////////////////////////////////////
reg a_next;
reg b_next;
// output a: inverted in the active-low polarities
always @* begin
    case (pol)
        `PDT_POL_AH: a_next = a_act;
        `PDT_POL_AL: a_next = !a_act;
        `PDT_POL_AHC: a_next = a_act;
        default: a_next = !a_act;
    endcase
end
// the fall path is already inverted, so b stays the inverse of a in both
// complementary polarities
always @* begin
    case (pol)
        `PDT_POL_AH: b_next = b_act;
        `PDT_POL_AL: b_next = !b_act;
        `PDT_POL_AHC: b_next = b_act;
        default: b_next = !b_act;
    endcase
end
// registered pair outputs
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pwm_out_a <= 1'b0;
    end else begin
        pwm_out_a <= a_next;
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pwm_out_b <= 1'b0;
    end else begin
        pwm_out_b <= b_next;
    end
end
////////////////////////////////////////////////////////////////////////////////
// event triggers: path 0 conv a, 1 conv b, 2 interrupt
wire [2:0] fire;
genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : trig
        wire [3:0] sel = trig_reg[g*`PDT_TRIG_STRIDE+`PDT_TRIG_SEL_HI:
            g*`PDT_TRIG_STRIDE+`PDT_TRIG_SEL_LO];
        wire [1:0] prd = trig_reg[g*`PDT_TRIG_STRIDE+`PDT_TRIG_PRD_HI:
            g*`PDT_TRIG_STRIDE+`PDT_TRIG_PRD_LO];
        wire en = trig_reg[g*`PDT_TRIG_STRIDE+`PDT_TRIG_EN];
        reg ev;
        reg [1:0] need;
        reg [1:0] cnt_reg;
        reg [1:0] cnt_next;
        reg fire_reg;
        reg fire_next;
        // events per pulse; the spare prescale code behaves as every event
        always @* begin
            case (prd)
                `PDT_PS_TWO: need = 2'h2;
                `PDT_PS_THREE: need = 2'h3;
                default: need = 2'h1;
            endcase
        end
        // event select
        always @* begin
            case (sel)
                `PDT_EV_ZERO: ev = count_at_zero;
                `PDT_EV_PRD: ev = count_at_period;
                `PDT_EV_ZP: ev = count_at_zero | count_at_period;
                `PDT_EV_UP0: ev = up_compare_match[0];
                `PDT_EV_UP0 + 4'h1: ev = up_compare_match[1];
                `PDT_EV_UP0 + 4'h2: ev = up_compare_match[2];
                `PDT_EV_UP0 + 4'h3: ev = up_compare_match[3];
                `PDT_EV_DN0: ev = down_compare_match[0];
                `PDT_EV_DN0 + 4'h1: ev = down_compare_match[1];
                `PDT_EV_DN0 + 4'h2: ev = down_compare_match[2];
                `PDT_EV_DN0 + 4'h3: ev = down_compare_match[3];
                `PDT_EV_DCA: ev = dig_cmp_a_event1;
                `PDT_EV_DCB: ev = dig_cmp_b_event1;
                default: ev = 1'b0;
            endcase
        end
        // prescale counter: counts selected events, restarts on each pulse
        always @* begin
            cnt_next = cnt_reg;
            fire_next = 1'b0;
            if (!en) begin
                cnt_next = 2'h0;
            end else if (ev) begin
                if (cnt_reg + 2'h1 >= need) begin
                    cnt_next = 2'h0;
                    fire_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg + 2'h1;
                end
            end
        end
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_reg <= 2'h0;
            end else begin
                cnt_reg <= cnt_next;
            end
        end
        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                fire_reg <= 1'b0;
            end else begin
                fire_reg <= fire_next;
            end
        end
        assign fire[g] = fire_reg;
        assign ev_cnt[g] = cnt_reg;
    end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// one-cycle output pulses, two cycles after the event
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        conv_trigger_a <= 1'b0;
    end else begin
        conv_trigger_a <= fire[0];
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        conv_trigger_b <= 1'b0;
    end else begin
        conv_trigger_b <= fire[1];
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq <= 1'b0;
    end else begin
        irq <= fire[2];
    end
end
endmodule // pdt_deadband_trigger

/* shared/pdt_regs.vh */
// Summary of operation
// - with dead-band enabled, delayed edges keep the output pair from overlapping active.
// - half-cycle clocking advances dead-band counters twice per time-base clock.
// - polarity is active high, active low, or either complementary; active high at reset.
// - both outputs sit at their inactive level throughout each dead-band interval.
// - complementary polarities drive B as the inverse of A, apart from delays, only while dead-band is enabled on output B.
// - rising-edge delay source selects A or B; A after reset.
// - falling-edge delay source selects A or B independently; A after reset.
// - rising-edge delay is 0 to 16383 time-base cycles.
// - falling-edge delay is 0 to 16383 time-base cycles.
// - each delay comes from the configured value or a live input, per source setting.
// - enabled A conversion trigger pulses on the selected event, after prescale.
// - A trigger fires every first, second or third event; every event at reset.
// - event can be count at zero, count at period, or either; zero at reset.
// - event can be any of four compare matches, counting up or down.
// - event can be digital-compare event 1 of channel A or B.
// - B conversion trigger has its own enable, prescale and event choice.
// - interrupt is off at reset and only produced while enabled.
// - interrupt fires every first, second or third event; every event at reset.
// - interrupt event choices match the A conversion trigger's.
`ifndef PDT_REGS_VH
`define PDT_REGS_VH
// register byte offsets
`define PDT_OFS_DBCTL 12'h000
`define PDT_OFS_RISE 12'h004
`define PDT_OFS_FALL 12'h008
`define PDT_OFS_TRIG 12'h00C
`define PDT_OFS_STAT 12'h010
// dead-band control fields
`define PDT_DB_EN_A 0
`define PDT_DB_EN_B 1
`define PDT_DB_HALF 2
`define PDT_DB_POL_LO 3
`define PDT_DB_POL_HI 4
`define PDT_DB_RSRC 5
`define PDT_DB_FSRC 6
`define PDT_DB_LIVE 7
`define PDT_DBCTL_W 8
// polarity codes
`define PDT_POL_AH 2'h0
`define PDT_POL_AL 2'h1
`define PDT_POL_AHC 2'h2
`define PDT_POL_ALC 2'h3
// trigger control: one byte per path (a, b, interrupt)
`define PDT_TRIG_SEL_LO 0
`define PDT_TRIG_SEL_HI 3
`define PDT_TRIG_PRD_LO 4
`define PDT_TRIG_PRD_HI 5
`define PDT_TRIG_EN 6
`define PDT_TRIG_STRIDE 8
// event select codes
`define PDT_EV_ZERO 4'h0
`define PDT_EV_PRD 4'h1
`define PDT_EV_ZP 4'h2
`define PDT_EV_UP0 4'h3
`define PDT_EV_DN0 4'h7
`define PDT_EV_DCA 4'hB
`define PDT_EV_DCB 4'hC
// event prescale codes
`define PDT_PS_ONE 2'h0
`define PDT_PS_TWO 2'h1
`define PDT_PS_THREE 2'h2
`endif

/* verification/pdt_partner.sv */
`timescale 1ns/1ns
module pdt_partner (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // converter starts and interrupt line
    input wire conv_trigger_a,
    input wire conv_trigger_b,
    input wire irq,
    // tallies of pulses taken
    output reg [7:0] n_a,
    output reg [7:0] n_b,
    output reg [7:0] n_i
);
    // the converter latches every one-cycle start pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_a <= 8'h00;
            n_b <= 8'h00;
            n_i <= 8'h00;
        end else begin
            n_a <= n_a + {7'h00, conv_trigger_a};
            n_b <= n_b + {7'h00, conv_trigger_b};
            n_i <= n_i + {7'h00, irq};
        end
    end
endmodule // pdt_partner

/* verification/pdt_chk_sva.sv */
`timescale 1ns/1ns
`include "pdt_regs.vh"
module pdt_chk (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // events and outputs
    input wire count_at_zero,
    input wire count_at_period,
    input wire pwm_out_a,
    input wire pwm_out_b,
    input wire conv_trigger_a,
    input wire conv_trigger_b,
    input wire irq
);
    reg [7:0] db_reg;
    reg [23:0] tr_reg;
    wire wr = psel && penable && pready && pwrite;
    // shadow copies of the control registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            db_reg <= 8'h00;
            tr_reg <= 24'h000000;
        end else if (wr && paddr == `PDT_OFS_DBCTL) begin
            db_reg <= pwdata[7:0];
        end else if (wr && paddr == `PDT_OFS_TRIG) begin
            tr_reg <= pwdata[23:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RDY: assert property (psel && !penable |=> pready)
        else $error("ready late");
    AST_RDY_ACC: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error reply");
    AST_NOOVL: assert property (db_reg[4:0] == 5'h03 |-> !(pwm_out_a && pwm_out_b))
        else $error("outputs overlap");
    AST_TRIGA: assert property (count_at_zero && tr_reg[6:0] == 7'h40 |-> ##2 conv_trigger_a)
        else $error("start a missing");
    AST_ACAUSE: assert property (conv_trigger_a && tr_reg[3:0] == 4'h0 |-> $past(count_at_zero, 2))
        else $error("start a without event");
    AST_BPRD: assert property (count_at_period && tr_reg[14:8] == 7'h41 |-> ##2 conv_trigger_b)
        else $error("start b missing");
    AST_PS2: assert property (conv_trigger_a && tr_reg[5:4] == 2'h1 |=> !conv_trigger_a)
        else $error("prescale two broken");
    AST_IRQOFF: assert property (!tr_reg[22] && !$past(tr_reg[22]) && !$past(tr_reg[22], 2) |-> !irq)
        else $error("interrupt while off");
endmodule // pdt_chk
bind pdt_deadband_trigger pdt_chk u_chk (.*);

/* verification/tb_top.sv */
`timescale 1ns/1ns
`include "pdt_regs.vh"
module tb_top;
    reg pclk, presetn, psel, penable, pwrite, timebase_clock, pwm_in_a, pwm_in_b, e;
    reg count_at_zero, count_at_period, dig_cmp_a_event1, dig_cmp_b_event1;
    reg [3:0] up_compare_match, down_compare_match;
    reg [11:0] paddr;
    reg [31:0] pwdata, q;
    reg [13:0] rise_live, fall_live;
    reg [7:0] a0, b0, i0;
    wire [31:0] prdata;
    wire pready, pslverr, pwm_out_a, pwm_out_b, conv_trigger_a, conv_trigger_b, irq;
    wire timebase_half = ~timebase_clock;
    wire [7:0] n_a, n_b, n_i;
    integer n_errors = 0, n_compared = 0, i, d, d0;
    pdt_deadband_trigger uut (.*);
    pdt_partner partner (.*);
    initial begin
        {pclk, presetn, psel, penable, pwrite, timebase_clock, pwm_in_a, pwm_in_b} = 8'h00;
        {count_at_zero, count_at_period, dig_cmp_a_event1, dig_cmp_b_event1} = 4'h0;
        {up_compare_match, down_compare_match, paddr, pwdata} = 52'h0;
        {rise_live, fall_live} = 28'h0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) timebase_clock <= ~timebase_clock;
    initial begin
        repeat (100000) @(posedge pclk);
        n_errors++;
        stop_test;
    end
    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        begin
            if (n_errors == 0 && n_compared > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task chk(input [31:0] s, input [31:0] x, input [63:0] nm);
        begin
            n_compared++;
            if (s !== x) begin
                n_errors++;
                $display("mismatch %0s expected %h seen %h", nm, x, s);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] v);
        integer k;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= v;
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            do begin
                @(posedge pclk);
                k++;
            end while (pready !== 1'b1 && k < 20);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (pready !== 1'b1) begin
                n_errors++;
                stop_test;
            end
        end
    endtask
    task ev(input [3:0] k);
        begin
            @(posedge pclk);
            count_at_zero <= k == 4'h0;
            count_at_period <= k == 4'h1 || k == 4'h2;
            up_compare_match <= (k >= 4'h3 && k <= 4'h6) ? 4'h1 << (k - 4'h3) : 4'h0;
            down_compare_match <= (k >= 4'h7 && k <= 4'hA) ? 4'h1 << (k - 4'h7) : 4'h0;
            dig_cmp_a_event1 <= k == 4'hB;
            dig_cmp_b_event1 <= k == 4'hC;
            @(posedge pclk);
            {count_at_zero, count_at_period, up_compare_match, down_compare_match} <= 10'h0;
            {dig_cmp_a_event1, dig_cmp_b_event1} <= 2'h0;
            repeat (4) @(posedge pclk);
        end
    endtask
    // source low, then a rising edge in a fixed tick phase; cycles to output a
    task meas;
        begin
            pwm_in_a <= 1'b0;
            repeat (30) @(posedge pclk);
            if (timebase_clock) @(posedge pclk);
            pwm_in_a <= 1'b1;
            for (d = 0; d < 100 && pwm_out_a !== 1'b1; d++) @(posedge pclk);
        end
    endtask
    task dly(input integer lo);
        begin
            meas;
            chk(d - d0 >= lo && d - d0 <= lo + 2, 1, "delay");
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 20; i = i + 4) begin
            apb(0, i[11:0], 0);
            chk(q, 0, "reset");
        end
        apb(0, 12'h014, 0);
        chk({31'h0, e}, 1, "slverr");
        chk(q, 0, "unmapped");
        for (i = 4; i <= 8; i = i + 4) begin
            apb(1, i[11:0], 32'hFFFF);
            apb(0, i[11:0], 0);
            chk(q, 32'h3FFF, "dly_reg");
            apb(1, i[11:0], 0);
        end
        pwm_in_a <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1, `PDT_OFS_DBCTL, 3 | i << 3);
            repeat (20) @(posedge pclk);
            if (i < 2)
                chk({pwm_out_a, pwm_out_b}, i ? 2'h1 : 2'h2, "pol");
            else
                chk(pwm_out_b, {31'h0, ~pwm_out_a}, "compl");
        end
        apb(1, `PDT_OFS_DBCTL, 3);
        meas;
        d0 = d;
        apb(1, `PDT_OFS_RISE, 4);
        dly(7);
        apb(1, `PDT_OFS_DBCTL, 7);
        dly(3);
        apb(1, `PDT_OFS_RISE, 0);
        rise_live <= 14'h0004;
        apb(1, `PDT_OFS_DBCTL, 32'h83);
        dly(7);
        for (i = 0; i < 3; i++) begin
            apb(1, `PDT_OFS_TRIG, {9'h0, i != 0, i[1:0], 12'h200, 2'h1, i[1:0], 4'h0});
            a0 = n_a;
            i0 = n_i;
            repeat (6) ev(4'h0);
            chk(n_a - a0, 6 / (i + 1), "conv_a");
            chk(n_i - i0, i ? 6 / (i + 1) : 0, "irq");
        end
        for (i = 0; i < 13; i++) begin
            apb(1, `PDT_OFS_TRIG, {16'h0, 4'h4, i[3:0], 8'h00});
            b0 = n_b;
            ev(i[3:0]);
            chk(n_b - b0, 1, "conv_b");
        end
        stop_test;
    end
endmodule // tb_top
